// File: mos_regs.v
`timescale 1ns/1ps
`include "mos_defines.vh"

module mos_regs #(
  parameter [31:0] OIS_PERIOD = `MOS_OIS_CYCLES,
  parameter [31:0] UI_FAST_PERIOD = `MOS_OIS_CYCLES
) (
  input wire clk_sys,
  input wire sys_rst,
  // Primary serial interface read port
  input wire pri_rd_en,
  input wire [7:0] pri_addr,
  output reg [7:0] pri_rdata_q,
  output reg pri_rvalid_q,
  // Auxiliary serial interface read port
  input wire aux_rd_en,
  input wire [7:0] aux_addr,
  output reg [7:0] aux_rdata_q,
  output reg aux_rvalid_q,
  // Settings held in control registers outside this group
  input wire [7:0] accel_control,
  input wire [7:0] stabilisation_control,
  input wire single_write_option,
  // Raw acceleration samples and the gyro stabilisation sample strobe
  input wire [15:0] accel_x_raw,
  input wire [15:0] accel_y_raw,
  input wire [15:0] accel_z_raw,
  input wire gyro_ois_sample,
  // Event pulses
  input wire long_counter_timeout_evt,
  input wire significant_motion_evt,
  input wire tilt_evt,
  input wire step_detect_evt,
  input wire [15:0] machine_evt,
  input wire [3:0] target_nack_evt,
  input wire target0_write_evt,
  input wire hub_sequence_evt,
  // Flag clears from the owning engines
  input wire emb_flags_clr,
  input wire machine_flags_clr,
  input wire hub_flags_clr,
  // Status outputs
  output reg aux_accel_data_available_q,
  output reg aux_gyro_data_available_q,
  output wire ui_sample_tick,
  output wire ois_sample_tick
);
  reg long_counter_timeout_flag_q;
  reg significant_motion_flag_q;
  reg tilt_flag_q;
  reg step_detect_flag_q;
  reg [15:0] machine_flags_q;
  reg [3:0] target_nack_q;
  reg single_write_done_q;
  reg hub_sequence_concluded_q;
  reg [15:0] ui_x_q;
  reg [15:0] ui_y_q;
  reg [15:0] ui_z_q;
  reg [15:0] ois_x_q;
  reg [15:0] ois_y_q;
  reg [15:0] ois_z_q;
  reg [7:0] pri_rdata_d;
  reg [7:0] aux_rdata_d;
  reg [31:0] ui_period;
  wire [3:0] ui_odr;
  wire ui_run;
  wire [1:0] ui_fs;
  wire [1:0] ois_fs;
  wire [47:0] raw_all;
  wire [47:0] ui_scaled;
  wire [47:0] ois_scaled;
  wire [7:0] emb_byte;
  wire [7:0] hub_byte;
  wire aux_accel_high_rd;
  wire aux_gyro_high_rd;

  assign ui_odr = accel_control[`MOS_XL_ODR_MSB:`MOS_XL_ODR_LSB];
  assign ui_fs = accel_control[`MOS_XL_FS_MSB:`MOS_XL_FS_LSB];
  assign ois_fs = stabilisation_control[`MOS_OIS_FS_MSB:`MOS_OIS_FS_LSB];
  assign raw_all = {accel_z_raw, accel_y_raw, accel_x_raw};

  // Unsupported rate codes behave as power-down rather than guessing a rate
  assign ui_run = (ui_odr != `MOS_ODR_OFF) && (ui_odr <= `MOS_ODR_MAX);

  // Each lower rate code halves the user output rate
  always @* begin
    ui_period = UI_FAST_PERIOD;
    if (ui_run) begin
      ui_period = UI_FAST_PERIOD << (`MOS_ODR_MAX - ui_odr);
    end
  end

  mos_rate_div u_ui_rate (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .run(ui_run),
    .period(ui_period),
    .tick_q(ui_sample_tick)
  );

  mos_rate_div u_ois_rate (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .run(1'b1),
    .period(OIS_PERIOD),
    .tick_q(ois_sample_tick)
  );

  genvar ax;
  generate
    for (ax = 0; ax < 3; ax = ax + 1) begin : g_axis
      mos_fs_scale u_ui_fs (
        .raw(raw_all[ax*16 +: 16]),
        .fs_code(ui_fs),
        .scaled(ui_scaled[ax*16 +: 16])
      );
      mos_fs_scale u_ois_fs (
        .raw(raw_all[ax*16 +: 16]),
        .fs_code(ois_fs),
        .scaled(ois_scaled[ax*16 +: 16])
      );
    end
  endgenerate

  // Whole 16-bit words are captured at once, but low and high byte reads split by a tick can mix samples
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ui_x_q <= `MOS_RST_WORD;
      ui_y_q <= `MOS_RST_WORD;
      ui_z_q <= `MOS_RST_WORD;
    end else if (ui_sample_tick) begin
      ui_x_q <= ui_scaled[15:0];
      ui_y_q <= ui_scaled[31:16];
      ui_z_q <= ui_scaled[47:32];
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ois_x_q <= `MOS_RST_WORD;
      ois_y_q <= `MOS_RST_WORD;
      ois_z_q <= `MOS_RST_WORD;
    end else if (ois_sample_tick) begin
      ois_x_q <= ois_scaled[15:0];
      ois_y_q <= ois_scaled[31:16];
      ois_z_q <= ois_scaled[47:32];
    end
  end

  // Embedded-function flags; a new event beats a clear in the same cycle
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      long_counter_timeout_flag_q <= 1'b0;
      significant_motion_flag_q <= 1'b0;
      tilt_flag_q <= 1'b0;
      step_detect_flag_q <= 1'b0;
    end else begin
      long_counter_timeout_flag_q <= long_counter_timeout_evt
        || (long_counter_timeout_flag_q && !emb_flags_clr);
      significant_motion_flag_q <= significant_motion_evt
        || (significant_motion_flag_q && !emb_flags_clr);
      tilt_flag_q <= tilt_evt || (tilt_flag_q && !emb_flags_clr);
      step_detect_flag_q <= step_detect_evt || (step_detect_flag_q && !emb_flags_clr);
    end
  end

  genvar m;
  generate
    for (m = 0; m < 16; m = m + 1) begin : g_machine
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          machine_flags_q[m] <= 1'b0;
        end else begin
          machine_flags_q[m] <= machine_evt[m]
            || (machine_flags_q[m] && !machine_flags_clr);
        end
      end
    end
  endgenerate

  genvar t;
  generate
    for (t = 0; t < 4; t = t + 1) begin : g_target
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          target_nack_q[t] <= 1'b0;
        end else begin
          target_nack_q[t] <= target_nack_evt[t]
            || (target_nack_q[t] && !hub_flags_clr);
        end
      end
    end
  endgenerate

  // Completion outside single-write mode is not reported
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      single_write_done_q <= 1'b0;
      hub_sequence_concluded_q <= 1'b0;
    end else begin
      single_write_done_q <= (single_write_option && target0_write_evt)
        || (single_write_done_q && !hub_flags_clr);
      hub_sequence_concluded_q <= hub_sequence_evt
        || (hub_sequence_concluded_q && !hub_flags_clr);
    end
  end

  // Status bytes built with unused positions tied low
  assign emb_byte = {long_counter_timeout_flag_q, 1'b0, significant_motion_flag_q,
    tilt_flag_q, step_detect_flag_q, 3'b000};
  assign hub_byte = {single_write_done_q, target_nack_q, 2'b00,
    hub_sequence_concluded_q};

  // Primary port sees the user chain and all status registers
  always @* begin
    pri_rdata_d = `MOS_RST_BYTE;
    if (pri_addr == `MOS_ACC_X_L) begin
      pri_rdata_d = ui_x_q[7:0];
    end else if (pri_addr == `MOS_ACC_X_H) begin
      pri_rdata_d = ui_x_q[15:8];
    end else if (pri_addr == `MOS_ACC_Y_L) begin
      pri_rdata_d = ui_y_q[7:0];
    end else if (pri_addr == `MOS_ACC_Y_H) begin
      pri_rdata_d = ui_y_q[15:8];
    end else if (pri_addr == `MOS_ACC_Z_L) begin
      pri_rdata_d = ui_z_q[7:0];
    end else if (pri_addr == `MOS_ACC_Z_H) begin
      pri_rdata_d = ui_z_q[15:8];
    end else if (pri_addr == `MOS_EMB_FLAGS) begin
      pri_rdata_d = emb_byte;
    end else if (pri_addr == `MOS_SM_FLAGS_LO) begin
      pri_rdata_d = machine_flags_q[7:0];
    end else if (pri_addr == `MOS_SM_FLAGS_HI) begin
      pri_rdata_d = machine_flags_q[15:8];
    end else if (pri_addr == `MOS_HUB_STATUS) begin
      pri_rdata_d = hub_byte;
    end else begin
      pri_rdata_d = `MOS_RST_BYTE;
    end
  end

  // Auxiliary port only ever sees stabilisation-chain outputs
  always @* begin
    aux_rdata_d = `MOS_RST_BYTE;
    if (aux_addr == `MOS_ACC_X_L) begin
      aux_rdata_d = ois_x_q[7:0];
    end else if (aux_addr == `MOS_ACC_X_H) begin
      aux_rdata_d = ois_x_q[15:8];
    end else if (aux_addr == `MOS_ACC_Y_L) begin
      aux_rdata_d = ois_y_q[7:0];
    end else if (aux_addr == `MOS_ACC_Y_H) begin
      aux_rdata_d = ois_y_q[15:8];
    end else if (aux_addr == `MOS_ACC_Z_L) begin
      aux_rdata_d = ois_z_q[7:0];
    end else if (aux_addr == `MOS_ACC_Z_H) begin
      aux_rdata_d = ois_z_q[15:8];
    end else begin
      aux_rdata_d = `MOS_RST_BYTE;
    end
  end

  // No write path exists, so contents cannot be altered from either port
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pri_rdata_q <= `MOS_RST_BYTE;
      pri_rvalid_q <= 1'b0;
      aux_rdata_q <= `MOS_RST_BYTE;
      aux_rvalid_q <= 1'b0;
    end else begin
      pri_rvalid_q <= pri_rd_en;
      aux_rvalid_q <= aux_rd_en;
      if (pri_rd_en) begin
        pri_rdata_q <= pri_rdata_d;
      end
      if (aux_rd_en) begin
        aux_rdata_q <= aux_rdata_d;
      end
    end
  end

  assign aux_accel_high_rd = aux_rd_en && ((aux_addr == `MOS_ACC_X_H)
    || (aux_addr == `MOS_ACC_Y_H) || (aux_addr == `MOS_ACC_Z_H));
  assign aux_gyro_high_rd = aux_rd_en && ((aux_addr == `MOS_GYR_X_H)
    || (aux_addr == `MOS_GYR_Y_H) || (aux_addr == `MOS_GYR_Z_H));

  // New sample in the read cycle keeps the flag, so no sample goes unseen
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      aux_accel_data_available_q <= 1'b0;
      aux_gyro_data_available_q <= 1'b0;
    end else begin
      aux_accel_data_available_q <= ois_sample_tick
        || (aux_accel_data_available_q && !aux_accel_high_rd);
      aux_gyro_data_available_q <= gyro_ois_sample
        || (aux_gyro_data_available_q && !aux_gyro_high_rd);
    end
  end
endmodule // mos_regs

// File: mos_defines.vh
`ifndef MOS_DEFINES_VH
`define MOS_DEFINES_VH

// Register offsets of the group
`define MOS_ACC_X_L 8'h28
`define MOS_ACC_X_H 8'h29
`define MOS_ACC_Y_L 8'h2a
`define MOS_ACC_Y_H 8'h2b
`define MOS_ACC_Z_L 8'h2c
`define MOS_ACC_Z_H 8'h2d
`define MOS_EMB_FLAGS 8'h35
`define MOS_SM_FLAGS_LO 8'h36
`define MOS_SM_FLAGS_HI 8'h37
`define MOS_HUB_STATUS 8'h39

// Gyro high bytes, only watched for the auxiliary data-available clear
`define MOS_GYR_X_H 8'h23
`define MOS_GYR_Y_H 8'h25
`define MOS_GYR_Z_H 8'h27

`define MOS_RST_BYTE 8'h00
`define MOS_RST_WORD 16'h0000

// Field positions in the status registers
`define MOS_EMB_LC_BIT 7
`define MOS_EMB_SIGMOT_BIT 5
`define MOS_EMB_TILT_BIT 4
`define MOS_EMB_STEP_BIT 3
`define MOS_HUB_WR_DONE_BIT 7
`define MOS_HUB_NACK_LSB 3
`define MOS_HUB_ENDOP_BIT 0

// Field positions in the control registers
`define MOS_XL_ODR_MSB 7
`define MOS_XL_ODR_LSB 4
`define MOS_XL_FS_MSB 3
`define MOS_XL_FS_LSB 2
`define MOS_OIS_FS_MSB 4
`define MOS_OIS_FS_LSB 3

// Output-rate codes and full-scale codes
`define MOS_ODR_OFF 4'h0
`define MOS_ODR_MAX 4'ha
`define MOS_FS_2G 2'b00
`define MOS_FS_16G 2'b01
`define MOS_FS_4G 2'b10
`define MOS_FS_8G 2'b11
`define MOS_SHIFT_2G 2'd3
`define MOS_SHIFT_4G 2'd2
`define MOS_SHIFT_8G 2'd1
`define MOS_SHIFT_16G 2'd0

// Timing
`define MOS_CLK_HZ 40000000
`define MOS_OIS_RATE_HZ 6660
`define MOS_OIS_CYCLES (`MOS_CLK_HZ / `MOS_OIS_RATE_HZ)
`define MOS_CNT_ONE 32'h00000001
`define MOS_CNT_ZERO 32'h00000000

`endif

// File: mos_rate_div.v
`timescale 1ns/1ps
`include "mos_defines.vh"

module mos_rate_div (
  input wire clk_sys,
  input wire sys_rst,
  input wire run,
  input wire [31:0] period,
  output reg tick_q
);
  reg [31:0] cnt_q;

  // Counter restarts whenever the rate stops; a change between running rates keeps the count
  always @(posedge clk_sys) begin
    if (sys_rst || !run) begin
      cnt_q <= `MOS_CNT_ZERO;
      tick_q <= 1'b0;
    end else if (cnt_q + `MOS_CNT_ONE >= period) begin
      cnt_q <= `MOS_CNT_ZERO;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + `MOS_CNT_ONE;
      tick_q <= 1'b0;
    end
  end
endmodule // mos_rate_div

// File: mos_fs_scale.v
`timescale 1ns/1ps
`include "mos_defines.vh"

module mos_fs_scale (
  input wire [15:0] raw,
  input wire [1:0] fs_code,
  output reg [15:0] scaled
);
  reg [1:0] sh;
  reg [18:0] wide;

  // Raw input spans the widest range; narrower ranges shift up and clip
  always @* begin
    sh = `MOS_SHIFT_16G;
    case (fs_code)
      `MOS_FS_2G: sh = `MOS_SHIFT_2G;
      `MOS_FS_4G: sh = `MOS_SHIFT_4G;
      `MOS_FS_8G: sh = `MOS_SHIFT_8G;
      default: sh = `MOS_SHIFT_16G;
    endcase
    wide = {{3{raw[15]}}, raw} << sh;
    if (wide[18:15] != {4{wide[18]}}) begin
      scaled = wide[18] ? 16'h8000 : 16'h7fff;
    end else begin
      scaled = wide[15:0];
    end
  end
endmodule // mos_fs_scale

// File: mos_regs_checker.sv
`timescale 1ns/1ps
module mos_regs_checker #(
  parameter [31:0] OIS_PERIOD = 32'h8
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire pri_rd_en,
  input wire [7:0] pri_addr,
  input wire [7:0] pri_rdata_q,
  input wire pri_rvalid_q,
  input wire aux_rd_en,
  input wire [7:0] aux_addr,
  input wire [7:0] aux_rdata_q,
  input wire aux_rvalid_q,
  input wire tilt_evt,
  input wire long_counter_timeout_evt,
  input wire [3:0] target_nack_evt,
  input wire aux_accel_data_available_q,
  input wire ois_sample_tick
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  reg [31:0] gap_q;
  reg seen_q;
  // First tick after reset has no known phase, so only later gaps count
  always @(posedge clk_sys) begin
    if (sys_rst || ois_sample_tick)
      gap_q <= 32'h0;
    else
      gap_q <= gap_q + 32'h1;
    if (sys_rst)
      seen_q <= 1'b0;
    else if (ois_sample_tick)
      seen_q <= 1'b1;
  end
  // Host needs a cycle or two to turn around from an event to its read
  sequence tilt_then_rd;
    tilt_evt ##[1:2] (pri_rd_en && pri_addr == 8'h35);
  endsequence
  sequence lc_then_rd;
    long_counter_timeout_evt ##[1:2] (pri_rd_en && pri_addr == 8'h35);
  endsequence
  sequence nack3_then_rd;
    target_nack_evt[3] ##[1:2] (pri_rd_en && pri_addr == 8'h39);
  endsequence
  // Back-to-back reads are legal, so valid is checked per request cycle
  AST_PRI_VALID: assert property (pri_rd_en |=> pri_rvalid_q)
    else $error("primary read valid missing one cycle after request");
  AST_PRI_IDLE: assert property (!pri_rd_en |=> !pri_rvalid_q)
    else $error("primary read valid without a request");
  AST_AUX_VALID: assert property (aux_rd_en |=> aux_rvalid_q)
    else $error("auxiliary read valid missing");
  AST_AUX_UNMAP: assert property ((aux_rd_en && (aux_addr < 8'h28 || aux_addr > 8'h2d))
    |=> aux_rdata_q == 8'h00)
    else $error("auxiliary read outside accel outputs not zero");
  AST_EMB_ZERO: assert property ((pri_rd_en && pri_addr == 8'h35)
    |=> pri_rdata_q[6] == 1'b0 && pri_rdata_q[2:0] == 3'h0)
    else $error("unused embedded status bits not zero");
  AST_TILT_SET: assert property (tilt_then_rd |=> pri_rdata_q[4])
    else $error("tilt flag not reported");
  AST_LC_SET: assert property (lc_then_rd |=> pri_rdata_q[7])
    else $error("long counter flag not reported");
  AST_NACK3_SET: assert property (nack3_then_rd |=> pri_rdata_q[6])
    else $error("target 3 nack flag not reported");
  AST_OIS_RATE: assert property ((ois_sample_tick && seen_q) |-> gap_q == OIS_PERIOD - 32'h1)
    else $error("stabilisation sample spacing wrong");
  AST_AUX_XL_CLR: assert property ((aux_rd_en && aux_addr inside {8'h29, 8'h2b, 8'h2d}
    && !ois_sample_tick) |=> !aux_accel_data_available_q || ois_sample_tick)
    else $error("accel data flag not cleared by high byte read");
endmodule // mos_regs_checker

bind mos_regs mos_regs_checker #(.OIS_PERIOD(OIS_PERIOD)) mos_regs_checker_i (
  .clk_sys, .sys_rst, .pri_rd_en, .pri_addr, .pri_rdata_q, .pri_rvalid_q,
  .aux_rd_en, .aux_addr, .aux_rdata_q, .aux_rvalid_q, .tilt_evt,
  .long_counter_timeout_evt, .target_nack_evt, .aux_accel_data_available_q,
  .ois_sample_tick
);

// File: mos_host_model.sv
`timescale 1ns/1ps
module mos_host_model (
  input wire clk_sys,
  output reg rd_en,
  output reg [7:0] addr,
  input wire [7:0] rdata_q,
  input wire rvalid_q
);
  initial begin
    rd_en = 1'b0;
    addr = 8'h00;
  end
  // Released address is inverted so a stale decode cannot look right
  task rd(input [7:0] a, output [7:0] d, output reg ok);
    integer i;
    begin
      @(posedge clk_sys);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      addr <= ~a;
      ok = 1'b0;
      d = 8'h00;
      for (i = 0; i < 4 && !ok; i = i + 1) begin
        @(posedge clk_sys);
        ok = (rvalid_q === 1'b1);
        d = rdata_q;
      end
    end
  endtask
endmodule // mos_host_model

// File: tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  checked = checked + 1; \
  if ((got) !== (exp)) begin \
    err_count = err_count + 1; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module tb_top;
  reg clk_sys;
  reg sys_rst;
  reg [7:0] accel_control;
  reg [7:0] stabilisation_control;
  reg single_write_option;
  reg [15:0] raw_x, raw_y, raw_z;
  // Gyro, lc, sigmot, tilt, step, machines, nacks, write, hub, clears
  reg [29:0] ev;
  wire pri_rd_en, pri_rvalid_q, aux_rd_en, aux_rvalid_q;
  wire [7:0] pri_addr, pri_rdata_q, aux_addr, aux_rdata_q;
  integer err_count, checked;
  reg [7:0] d;
  reg ok;
  wire ui_tick, gyro_flag;
  integer n_ticks;
  mos_regs #(.OIS_PERIOD(32'h8), .UI_FAST_PERIOD(32'h8)) mos_regs_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .pri_rd_en(pri_rd_en), .pri_addr(pri_addr), .pri_rdata_q(pri_rdata_q),
    .pri_rvalid_q(pri_rvalid_q), .aux_rd_en(aux_rd_en), .aux_addr(aux_addr),
    .aux_rdata_q(aux_rdata_q), .aux_rvalid_q(aux_rvalid_q),
    .accel_control(accel_control), .stabilisation_control(stabilisation_control),
    .single_write_option(single_write_option), .accel_x_raw(raw_x),
    .accel_y_raw(raw_y), .accel_z_raw(raw_z), .gyro_ois_sample(ev[29]),
    .long_counter_timeout_evt(ev[28]), .significant_motion_evt(ev[27]),
    .tilt_evt(ev[26]), .step_detect_evt(ev[25]), .machine_evt(ev[24:9]),
    .target_nack_evt(ev[8:5]), .target0_write_evt(ev[4]), .hub_sequence_evt(ev[3]),
    .emb_flags_clr(ev[2]), .machine_flags_clr(ev[1]), .hub_flags_clr(ev[0]),
    .aux_accel_data_available_q(), .aux_gyro_data_available_q(gyro_flag),
    .ui_sample_tick(ui_tick), .ois_sample_tick()
  );
  mos_host_model mos_host_model_i (.clk_sys(clk_sys), .rd_en(pri_rd_en),
    .addr(pri_addr), .rdata_q(pri_rdata_q), .rvalid_q(pri_rvalid_q));
  mos_host_model mos_host_model_aux_i (.clk_sys(clk_sys), .rd_en(aux_rd_en),
    .addr(aux_addr), .rdata_q(aux_rdata_q), .rvalid_q(aux_rvalid_q));
  task give_verdict;
    begin
      if (err_count == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input sel, input [7:0] a, input [7:0] e);
    begin
      if (sel)
        mos_host_model_i.rd(a, d, ok);
      else
        mos_host_model_aux_i.rd(a, d, ok);
      if (ok !== 1'b1) begin
        err_count = err_count + 1;
        give_verdict;
      end else
        `CHK(d, e)
    end
  endtask
  task chk_axes(input sel, input [15:0] x, input [15:0] y, input [15:0] z);
    reg [47:0] v;
    integer k;
    begin
      v = {z, y, x};
      for (k = 0; k < 6; k = k + 1)
        chk(sel, 8'h28 + k[7:0], v[k*8 +: 8]);
    end
  endtask
  // One-cycle pulse; clear and set may share it to test set priority
  task pulse(input [29:0] v);
    begin
      @(posedge clk_sys);
      ev <= v;
      @(posedge clk_sys);
      ev <= 30'h0;
    end
  endtask
  // Counts user-chain ticks seen over n edges
  task count_ticks(input integer n, output integer c);
    integer j;
    begin
      c = 0;
      for (j = 0; j < n; j = j + 1) begin
        @(posedge clk_sys);
        c = c + ui_tick;
      end
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    err_count = 0;
    checked = 0;
    sys_rst = 1'b1;
    accel_control = 8'h00;
    stabilisation_control = 8'h00;
    single_write_option = 1'b0;
    raw_x = 16'hfff0;
    raw_y = 16'h9000;
    raw_z = 16'h2000;
    ev = 30'h0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    chk_axes(1'b1, 16'h0000, 16'h0000, 16'h0000);
    chk(1'b1, 8'h35, 8'h00);
    chk(1'b1, 8'h36, 8'h00);
    chk(1'b1, 8'h37, 8'h00);
    chk(1'b1, 8'h39, 8'h00);
    chk(1'b1, 8'h30, 8'h00);
    accel_control <= 8'ha0;
    repeat (8) @(posedge clk_sys);
    count_ticks(32, n_ticks);
    `CHK(n_ticks, 4)
    chk_axes(1'b1, 16'hff80, 16'h8000, 16'h7fff);
    accel_control <= 8'ha4;
    repeat (40) @(posedge clk_sys);
    chk_axes(1'b1, 16'hfff0, 16'h9000, 16'h2000);
    accel_control <= 8'h9c;
    repeat (20) @(posedge clk_sys);
    count_ticks(32, n_ticks);
    `CHK(n_ticks, 2)
    chk_axes(1'b1, 16'hffe0, 16'h8000, 16'h4000);
    // Rate code zero freezes the outputs
    // Raw input moves only once a tick launched before the stop has passed
    accel_control <= 8'h0c;
    repeat (2) @(posedge clk_sys);
    raw_x <= 16'h0001;
    count_ticks(58, n_ticks);
    `CHK(n_ticks, 0)
    chk_axes(1'b1, 16'hffe0, 16'h8000, 16'h4000);
    stabilisation_control <= 8'h18;
    repeat (40) @(posedge clk_sys);
    chk_axes(1'b0, 16'h0002, 16'h8000, 16'h4000);
    pulse(30'h20000000);
    @(posedge clk_sys);
    `CHK(gyro_flag, 1'b1)
    chk(1'b0, 8'h23, 8'h00);
    `CHK(gyro_flag, 1'b0)
    chk(1'b0, 8'h35, 8'h00);
    pulse(30'h04000000);
    chk(1'b1, 8'h35, 8'h10);
    pulse(30'h1a000000);
    chk(1'b1, 8'h35, 8'hb8);
    pulse(30'h00000004);
    chk(1'b1, 8'h35, 8'h00);
    pulse({5'h0, 16'h8001, 9'h0});
    chk(1'b1, 8'h36, 8'h01);
    chk(1'b1, 8'h37, 8'h80);
    pulse({5'h0, 16'h0002, 9'h002});
    chk(1'b1, 8'h36, 8'h02);
    chk(1'b1, 8'h37, 8'h00);
    pulse(30'h00000010);
    chk(1'b1, 8'h39, 8'h00);
    single_write_option <= 1'b1;
    pulse(30'h00000010);
    chk(1'b1, 8'h39, 8'h80);
    pulse({21'h0, 4'h9, 5'h0});
    chk(1'b1, 8'h39, 8'hc8);
    pulse(30'h00000008);
    chk(1'b1, 8'h39, 8'hc9);
    chk(1'b1, 8'h39, 8'hc9);
    pulse(30'h00000001);
    chk(1'b1, 8'h39, 8'h00);
    give_verdict;
  end
endmodule // tb_top
